// *** design/mrd_map.svh ***
// Offsets, field positions and reset values of the mapped register block
// Assumes inclusion by bare name from the block's design files
`ifndef MRD_MAP_SVH
`define MRD_MAP_SVH

// Register selects, taken from the two lowest address bits only
`define MRD_OFS_PORT 2'h0
`define MRD_OFS_CTRL 2'h1
`define MRD_OFS_STRB 2'h2
`define MRD_OFS_PTR 2'h3

// Control register: three implemented bits
`define MRD_CTRL_W 3
`define MRD_CTRL_EDGE_EN 0
`define MRD_CTRL_DONE_EN 1
`define MRD_CTRL_FETCH_EN 2
`define MRD_CTRL_RST 3'h0

// Sticky status flags
`define MRD_FLAG_W 2
`define MRD_FLAG_EDGE 0
`define MRD_FLAG_DONE 1
`define MRD_FLAG_RST 2'h0

// Reset values of the output side, and the all-ones read drive byte
`define MRD_PORT_RST 8'h00
`define MRD_BYTE_ZERO 8'h00
`define MRD_BYTE_ALL 8'hff

`endif

// *** design/mrd_pkg.sv ***
// Types shared by the mapped register block
// Assumes nothing of its surroundings
`default_nettype none

package mrd_pkg;

  typedef enum logic [1:0] {
    MRD_IDLE,
    MRD_FETCH_LO,
    MRD_FETCH_HI
  } mrd_fetch_state_t;

endpackage

`default_nettype wire

// *** design/mrd_fetch_if.sv ***
// Carrier between the register block, its address generator and shifter
// Assumes all three parties run on the same clock
`timescale 1ns/1ps
`default_nettype none

interface mrd_fetch_if #(
  parameter int ADDR_W = 16,
  parameter int WORD_W = 16
);
  logic step;
  logic load;
  logic [ADDR_W-1:0] load_addr;
  logic [ADDR_W-1:0] addr;
  logic shift_load;
  logic [WORD_W-1:0] word;
  logic pixel;
  logic pixel_valid;
  logic busy;

  modport gen (input step, load, load_addr, output addr);
  modport shf (input shift_load, word, output pixel, pixel_valid, busy);
  modport ctl (output step, load, load_addr, shift_load, word,
               input addr, pixel, pixel_valid, busy);
endinterface

`default_nettype wire

// *** design/mrd_addr_gen.sv ***
// Fetch address generator that wraps inside its aligned block
// Assumes one clock and an asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none

module mrd_addr_gen #(
  parameter int ADDR_W = 16,
  parameter int ALIGN_W = 8
) (
  input wire logic i_ref_clk,  // Bus clock
  input wire logic i_rst_n,    // Asynchronous reset, active low
  mrd_fetch_if.gen fif         // Step and load requests, address out
);
  logic [ADDR_W-1:0] addr;
  wire logic [ALIGN_W-1:0] low_inc;
  wire logic [ADDR_W-1:0] next_addr;

  // Carry stops at the block boundary: upper bits never change on a step
  assign low_inc = addr[ALIGN_W-1:0] + {{(ALIGN_W-1){1'b0}}, 1'b1};
  assign next_addr = fif.load ? fif.load_addr :
                     fif.step ? {addr[ADDR_W-1:ALIGN_W], low_inc} : addr;
  assign fif.addr = addr;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      addr <= '0;
    end else begin
      addr <= next_addr;
    end
  end

  a_wrap_block: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (fif.step && !fif.load) |=>
      (addr[ADDR_W-1:ALIGN_W] == $past(addr[ADDR_W-1:ALIGN_W])) &&
      (addr[ALIGN_W-1:0] == $past(addr[ALIGN_W-1:0]) + 1'b1))
    else $error("address step left its aligned block");
endmodule

`default_nettype wire

// *** design/mrd_pix_shift.sv ***
// Pixel shifter: sends a fetched word out most significant bit first
// Assumes one clock and an asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none

module mrd_pix_shift #(
  parameter int WORD_W = 16
) (
  input wire logic i_ref_clk,  // Bus clock
  input wire logic i_rst_n,    // Asynchronous reset, active low
  mrd_fetch_if.shf fif         // Word in, pixel stream out
);
  localparam int CNT_W = $clog2(WORD_W + 1);
  logic [WORD_W-1:0] shreg;
  logic [CNT_W-1:0] left;
  logic pixel;
  logic pixel_valid;
  wire logic more;

  assign more = (left != '0);
  assign fif.pixel = pixel;
  assign fif.pixel_valid = pixel_valid;
  assign fif.busy = more;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      shreg <= '0;
      left <= '0;
      pixel <= 1'b0;
      pixel_valid <= 1'b0;
    end else if (fif.shift_load) begin
      // Leftmost pixel is the word's most significant bit
      pixel <= fif.word[WORD_W-1];
      pixel_valid <= 1'b1;
      shreg <= {fif.word[WORD_W-2:0], 1'b0};
      left <= CNT_W'(WORD_W - 1);
    end else begin
      pixel <= shreg[WORD_W-1];
      pixel_valid <= more;
      shreg <= {shreg[WORD_W-2:0], 1'b0};
      left <= more ? left - 1'b1 : left;
    end
  end

  a_msb_first: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    fif.shift_load |=> pixel_valid && (pixel == $past(fif.word[WORD_W-1]))
      ##1 (pixel == $past(fif.word[WORD_W-2], 2)))
    else $error("pixel order is not most significant first");
endmodule

`default_nettype wire

// *** design/mrd_mapped_register_decode.sv ***
// Mapped register block on an 8-bit processor bus, four mirrored locations
// Assumes i_cs already decodes the 256-byte region and i_bank_cs the bank
// region; all inputs are synchronous to i_ref_clk
`timescale 1ns/1ps
`default_nettype none
`include "mrd_map.svh"

module mrd_mapped_register_decode #(
  parameter int BANK_W = 3,
  parameter int ADDR_W = 16,
  parameter int ALIGN_W = 8
) (
  input wire logic i_ref_clk,                // Bus clock, 100 MHz
  input wire logic i_rst_n,                  // Asynchronous reset, low
  input wire logic i_cs,                     // Register region selected
  input wire logic i_rw,                     // 1 read, 0 write
  input wire logic [7:0] i_addr,             // Low address byte
  input wire logic [7:0] i_wdata,            // Write data
  input wire logic i_bank_cs,                // Bank region selected
  input wire logic [7:0] i_port_pins,        // Present level of port pins
  input wire logic i_port_edge,              // Port interrupt input
  input wire logic [7:0] i_unit_present,     // One bit per attached unit
  input wire logic i_fetch_ack,              // Fetch byte returned
  input wire logic [7:0] i_fetch_data,       // Fetched byte
  output logic [7:0] o_rdata,                // Read data
  output logic [7:0] o_rdata_oe,             // Per-bit read data drive
  output logic [7:0] o_port_out,             // Port output latch
  output logic o_irq_n,                      // Interrupt request, low
  output logic o_strobe,                     // Strobe action pulse
  output logic [BANK_W-1:0] o_bank,          // Selected bank
  output logic o_fetch_req,                  // Fetch request
  output logic [ADDR_W-1:0] o_fetch_addr,    // Fetch byte address
  output logic o_pixel,                      // Pixel stream
  output logic o_pixel_valid                 // Pixel stream valid
);
  localparam int WORD_W = 16;

  function automatic logic hit(input logic [1:0] sel,
                               input logic [1:0] ofs);
    hit = (sel == ofs);
  endfunction

  mrd_fetch_if #(.ADDR_W(ADDR_W), .WORD_W(WORD_W)) fif ();

  mrd_addr_gen #(.ADDR_W(ADDR_W), .ALIGN_W(ALIGN_W)) u_gen (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .fif(fif.gen)
  );

  mrd_pix_shift #(.WORD_W(WORD_W)) u_shift (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .fif(fif.shf)
  );

  logic [`MRD_CTRL_W-1:0] ctrl;
  logic [`MRD_FLAG_W-1:0] flags;
  logic port_edge_d;
  logic ptr_phase;
  logic [7:0] ptr_lo;
  logic [7:0] word_lo;
  logic pixel;
  logic pixel_valid;
  mrd_pkg::mrd_fetch_state_t state;
  mrd_pkg::mrd_fetch_state_t next_state;

  // Address decode: bits 7..2 never take part, so all images are equal
  wire logic [1:0] sel = i_addr[1:0];
  wire logic acc_rd = i_cs & i_rw;
  wire logic acc_wr = i_cs & ~i_rw;
  wire logic wr_port = acc_wr & hit(sel, `MRD_OFS_PORT);
  wire logic wr_ctrl = acc_wr & hit(sel, `MRD_OFS_CTRL);
  wire logic wr_strb = acc_wr & hit(sel, `MRD_OFS_STRB);
  wire logic wr_ptr = acc_wr & hit(sel, `MRD_OFS_PTR);
  wire logic rd_port = acc_rd & hit(sel, `MRD_OFS_PORT);
  wire logic rd_ctrl = acc_rd & hit(sel, `MRD_OFS_CTRL);
  wire logic rd_strb = acc_rd & hit(sel, `MRD_OFS_STRB);
  wire logic rd_ptr = acc_rd & hit(sel, `MRD_OFS_PTR);

  // Events and the fetch engine
  wire logic fetching = (state != mrd_pkg::MRD_IDLE);
  wire logic fetch_done = (state == mrd_pkg::MRD_FETCH_HI) & i_fetch_ack;
  wire logic start = wr_strb & ctrl[`MRD_CTRL_FETCH_EN] & ~fetching;
  wire logic busy = fetching | fif.busy;
  wire logic edge_evt = port_edge_d & ~i_port_edge &
                        ctrl[`MRD_CTRL_EDGE_EN];
  wire logic done_evt = fetch_done & ctrl[`MRD_CTRL_DONE_EN];

  // Flags: a new event in the clearing cycle wins over the clear
  wire logic [`MRD_FLAG_W-1:0] next_flags = {
    done_evt | (flags[`MRD_FLAG_DONE] & ~rd_ptr),
    edge_evt | (flags[`MRD_FLAG_EDGE] & ~rd_port)
  };

  // Read side is unrelated to what the same address stores on a write
  wire logic [7:0] next_rdata =
    rd_port ? i_port_pins :
    rd_ctrl ? {{(8-`MRD_FLAG_W){1'b0}}, flags} :
    rd_strb ? i_unit_present :
    rd_ptr ? {7'h00, busy} : `MRD_BYTE_ZERO;
  // Presence status only drives bits of units that are attached
  wire logic [7:0] next_oe = !acc_rd ? `MRD_BYTE_ZERO :
                             rd_strb ? i_unit_present :
                             `MRD_BYTE_ALL;

  always_comb begin
    next_state = state;
    case (state)
      mrd_pkg::MRD_IDLE: begin
        if (start) begin
          next_state = mrd_pkg::MRD_FETCH_LO;
        end
      end
      mrd_pkg::MRD_FETCH_LO: begin
        if (i_fetch_ack) begin
          next_state = mrd_pkg::MRD_FETCH_HI;
        end
      end
      mrd_pkg::MRD_FETCH_HI: begin
        if (i_fetch_ack) begin
          next_state = mrd_pkg::MRD_IDLE;
        end
      end
      default: begin
        next_state = mrd_pkg::MRD_IDLE;
      end
    endcase
  end

  // Pointer writes come low byte first; the second write loads the word
  assign fif.load = wr_ptr & ptr_phase;
  assign fif.load_addr = {i_wdata, ptr_lo};
  assign fif.step = fetching & i_fetch_ack;
  // Byte fetched first is the word's low half
  assign fif.shift_load = fetch_done;
  assign fif.word = {i_fetch_data, word_lo};
  assign o_fetch_addr = fif.addr;
  assign pixel = fif.pixel;
  assign pixel_valid = fif.pixel_valid;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl <= `MRD_CTRL_RST;
      flags <= `MRD_FLAG_RST;
      o_port_out <= `MRD_PORT_RST;
      o_rdata <= `MRD_BYTE_ZERO;
      o_rdata_oe <= `MRD_BYTE_ZERO;
      o_irq_n <= 1'b1;
      o_strobe <= 1'b0;
      o_bank <= '0;
      port_edge_d <= 1'b1;
      ptr_phase <= 1'b0;
      ptr_lo <= `MRD_BYTE_ZERO;
      word_lo <= `MRD_BYTE_ZERO;
      state <= mrd_pkg::MRD_IDLE;
      o_fetch_req <= 1'b0;
      o_pixel <= 1'b0;
      o_pixel_valid <= 1'b0;
    end else begin
      flags <= next_flags;
      o_rdata <= next_rdata;
      o_rdata_oe <= next_oe;
      // Released high only when no flag remains set
      o_irq_n <= ~(|next_flags);
      o_strobe <= wr_strb;
      port_edge_d <= i_port_edge;
      state <= next_state;
      o_fetch_req <= (next_state != mrd_pkg::MRD_IDLE);
      o_pixel <= pixel;
      o_pixel_valid <= pixel_valid;
      if (wr_port) begin
        o_port_out <= i_wdata;
      end
      if (wr_ctrl) begin
        ctrl <= i_wdata[`MRD_CTRL_W-1:0];
      end
      // Bank decode looks at the address only, not at the direction
      if (i_bank_cs) begin
        o_bank <= i_addr[BANK_W-1:0];
      end
      if (wr_strb) begin
        ptr_phase <= 1'b0;
      end else if (wr_ptr) begin
        ptr_phase <= ~ptr_phase;
      end
      if (wr_ptr && !ptr_phase) begin
        ptr_lo <= i_wdata;
      end
      if (state == mrd_pkg::MRD_FETCH_LO && i_fetch_ack) begin
        word_lo <= i_fetch_data;
      end
    end
  end

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);

  a_irq_held_low: assert property ((|flags) |-> !o_irq_n)
    else $error("flag set but interrupt request not low");
  a_irq_sticky: assert property (
    (flags[`MRD_FLAG_DONE] && !rd_ptr) |=> flags[`MRD_FLAG_DONE])
    else $error("done flag dropped without acknowledge");
  a_port_read_pins: assert property (
    rd_port |=> (o_rdata == $past(i_port_pins)) && (o_rdata_oe == 8'hff))
    else $error("port read did not return pin levels");
  a_narrow_ctrl: assert property (
    wr_ctrl |=> (ctrl == $past(i_wdata[`MRD_CTRL_W-1:0])) &&
      (o_rdata[7:`MRD_FLAG_W] == '0 || !$past(rd_ctrl)))
    else $error("control write kept wrong bits");
  a_presence_float: assert property (
    rd_strb |=> o_rdata_oe == $past(i_unit_present))
    else $error("presence bits of absent units were driven");
  a_strobe_every: assert property (
    wr_strb ##1 wr_strb |=> o_strobe && $past(o_strobe))
    else $error("repeated strobe write did not fire twice");
  a_port_clear: assert property (
    (rd_port && !edge_evt) |=> !flags[`MRD_FLAG_EDGE])
    else $error("port read did not clear its flag");
  a_bank_on_read: assert property (
    (i_bank_cs && i_rw) |=> o_bank == $past(i_addr[BANK_W-1:0]))
    else $error("bank did not switch on a read");
  a_mirror_image: assert property (
    (acc_wr && i_addr[1:0] == 2'h0) |=> o_port_out == $past(i_wdata))
    else $error("mirrored port write missed");
  a_word_order: assert property (
    fetch_done |-> fif.word == {i_fetch_data, word_lo})
    else $error("fetched word bytes out of order");

  // Flag latching, strobes and read side effects, one cycle each
  a_irq_release: assert property (
    !(|flags) |-> o_irq_n)
    else $error("interrupt request low with no flag set");
  a_edge_latch: assert property (
    edge_evt |=> flags[`MRD_FLAG_EDGE] && !o_irq_n)
    else $error("port edge did not latch its flag");
  a_edge_sticky: assert property (
    (flags[`MRD_FLAG_EDGE] && !rd_port) |=> flags[`MRD_FLAG_EDGE])
    else $error("edge flag dropped without port read");
  a_done_latch: assert property (
    done_evt |=> flags[`MRD_FLAG_DONE] && !o_irq_n)
    else $error("fetch end did not latch its flag");
  a_ptr_clear: assert property (
    (rd_ptr && !done_evt) |=> !flags[`MRD_FLAG_DONE])
    else $error("pointer read did not clear done flag");
  a_strobe_pulse: assert property (
    wr_strb |=> o_strobe)
    else $error("strobe write did not pulse");
  a_strobe_quiet: assert property (
    !wr_strb |=> !o_strobe)
    else $error("strobe pulsed without a write");
  a_strobe_fetch: assert property (
    start |=> o_fetch_req)
    else $error("enabled strobe did not start a fetch");
  a_ctrl_read_fixed: assert property (
    rd_ctrl |=> (o_rdata[7:`MRD_FLAG_W] == '0) &&
      (o_rdata_oe == `MRD_BYTE_ALL))
    else $error("unused flag read bits not driven low");
  a_oe_idle: assert property (
    !acc_rd |=> o_rdata_oe == `MRD_BYTE_ZERO)
    else $error("read data driven outside a read");
  a_port_hold: assert property (
    !wr_port |=> $stable(o_port_out))
    else $error("port latch changed without a write");
  a_ctrl_hold: assert property (
    !wr_ctrl |=> $stable(ctrl))
    else $error("control changed without a write");
  a_bank_on_write: assert property (
    (i_bank_cs && !i_rw) |=> o_bank == $past(i_addr[BANK_W-1:0]))
    else $error("bank did not switch on a write");

  // Byte and bit order of the fetch path
  a_ptr_load: assert property (
    (wr_ptr && ptr_phase) |=>
      o_fetch_addr == {$past(i_wdata), $past(ptr_lo)})
    else $error("pointer bytes loaded in the wrong order");
  a_low_byte_first: assert property (
    (state == mrd_pkg::MRD_FETCH_LO && i_fetch_ack) |=>
      word_lo == $past(i_fetch_data))
    else $error("first fetched byte not kept as low byte");
  a_pixel_lead: assert property (
    fetch_done |->
      ##2 (o_pixel_valid && (o_pixel == $past(i_fetch_data[7], 2))))
    else $error("first pixel is not the high byte msb");

  c_fetch_word: cover property (start ##[1:20] fetch_done);
  c_port_irq: cover property (edge_evt ##[1:20] rd_port);
  c_strobe_pair: cover property (wr_strb ##1 wr_strb);
  c_bank_read: cover property (i_bank_cs && i_rw);
  c_presence_read: cover property (rd_strb);
endmodule

`default_nettype wire

// *** testbench/mrd_fetch_mem.sv ***
// Memory model that answers byte fetches of the register block
// Assumes the block's clock and reset; DELAY sets the wait before each ack
`timescale 1ns/1ps
`default_nettype none

module mrd_fetch_mem #(
  parameter int DELAY = 2
) (
  input wire logic i_ref_clk,      // Bus clock
  input wire logic i_rst_n,        // Asynchronous reset, active low
  input wire logic i_req,          // Fetch request from the block
  input wire logic [15:0] i_addr,  // Fetch byte address
  output logic o_ack,              // Byte valid this cycle
  output logic [7:0] o_data        // Fetched byte
);
  logic [3:0] cnt;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt <= 4'h0;
      o_ack <= 1'b0;
      o_data <= 8'h00;
    end else if (!i_req || o_ack) begin
      cnt <= 4'h0;
      o_ack <= 1'b0;
      o_data <= ~o_data;
    end else if (cnt == 4'(DELAY)) begin
      // Byte content is a fixed function of its address
      o_ack <= 1'b1;
      o_data <= i_addr[7:0] ^ 8'h3c;
    end else begin
      cnt <= cnt + 4'h1;
      o_data <= ~o_data;
    end
  end
endmodule

`default_nettype wire

// *** testbench/mrd_mapped_register_decode_tb_top.sv ***
// Self-checking bench of the mapped register block
// Assumes the design files and the fetch memory model are compiled first
`timescale 1ns/1ps
`default_nettype none

module mrd_mapped_register_decode_tb_top;
  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_cs = 1'b0;
  logic i_rw = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_bank_cs = 1'b0;
  logic [7:0] i_port_pins = 8'h00;
  logic i_port_edge = 1'b1;
  logic [7:0] i_unit_present = 8'h00;
  logic fetch_ack;
  logic [7:0] fetch_data;
  logic [7:0] o_rdata, o_rdata_oe, o_port_out;
  logic o_irq_n, o_strobe, o_fetch_req, o_pixel, o_pixel_valid;
  logic [2:0] o_bank;
  logic [15:0] o_fetch_addr;
  int errors = 0;
  int samples_checked = 0;
  int strobes = 0;
  logic [15:0] ack_addr [0:1];
  int acks = 0;

  always #5 i_ref_clk = ~i_ref_clk;

  mrd_mapped_register_decode #(.BANK_W(3), .ADDR_W(16), .ALIGN_W(8)) u_dut (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_cs(i_cs), .i_rw(i_rw),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_bank_cs(i_bank_cs),
    .i_port_pins(i_port_pins), .i_port_edge(i_port_edge),
    .i_unit_present(i_unit_present), .i_fetch_ack(fetch_ack),
    .i_fetch_data(fetch_data), .o_rdata(o_rdata), .o_rdata_oe(o_rdata_oe),
    .o_port_out(o_port_out), .o_irq_n(o_irq_n), .o_strobe(o_strobe),
    .o_bank(o_bank), .o_fetch_req(o_fetch_req), .o_fetch_addr(o_fetch_addr),
    .o_pixel(o_pixel), .o_pixel_valid(o_pixel_valid));

  mrd_fetch_mem #(.DELAY(3)) u_mem (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_req(o_fetch_req),
    .i_addr(o_fetch_addr), .o_ack(fetch_ack), .o_data(fetch_data));

  always @(posedge i_ref_clk) begin
    if (o_strobe === 1'b1) strobes++;
    if (fetch_ack === 1'b1 && acks < 2) begin
      ack_addr[acks] = o_fetch_addr;
      acks++;
    end
  end

  task automatic chk(input bit ok, input string m);
    samples_checked++;
    if (!ok) begin
      errors++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // One bus access; read data is settled just after the taking edge
  task automatic bus(input logic rw, input logic [7:0] a, input logic [7:0] d,
                     input logic bank);
    @(posedge i_ref_clk);
    i_cs <= ~bank;
    i_bank_cs <= bank;
    i_rw <= rw;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_cs <= 1'b0;
    i_bank_cs <= 1'b0;
    #1;
  endtask

  task automatic t_reset;
    chk(o_irq_n === 1'b1, "irq not negated after reset");
    chk(o_port_out === 8'h00 && o_strobe === 1'b0, "reset outputs");
  endtask

  task automatic t_mirror;
    bus(1'b0, 8'hfc, 8'ha6, 1'b0);
    chk(o_port_out === 8'ha6, "port latch via image fc");
    @(posedge i_ref_clk);
    i_port_pins <= 8'h5b;
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, 8'(k * 64), 8'h00, 1'b0);
      chk(o_rdata === 8'h5b, "port read not pins");
      chk(o_rdata_oe === 8'hff, "port read drive");
    end
  endtask

  task automatic t_narrow;
    bus(1'b0, 8'h01, 8'hf8, 1'b0);
    bus(1'b1, 8'h81, 8'h00, 1'b0);
    chk(o_rdata === 8'h00 && o_rdata_oe === 8'hff, "flags read");
    @(posedge i_ref_clk);
    i_unit_present <= 8'ha5;
    bus(1'b1, 8'h06, 8'h00, 1'b0);
    chk(o_rdata_oe === 8'ha5, "absent units driven");
    chk((o_rdata & 8'ha5) === 8'ha5, "presence bits");
  endtask

  task automatic t_strobe;
    strobes = 0;
    // Two strobe writes on back-to-back cycles, request held up between
    @(posedge i_ref_clk);
    i_cs <= 1'b1;
    i_rw <= 1'b0;
    i_addr <= 8'h02;
    i_wdata <= 8'h13;
    repeat (2) @(posedge i_ref_clk);
    i_cs <= 1'b0;
    #1;
    chk(o_strobe === 1'b1, "second strobe of pair");
    bus(1'b0, 8'h02, 8'h77, 1'b0);
    bus(1'b0, 8'h02, 8'h77, 1'b0);
    bus(1'b0, 8'hfe, 8'h00, 1'b0);
    repeat (2) @(posedge i_ref_clk);
    chk(strobes == 5, "strobe count");
    chk(o_fetch_req === 1'b0, "fetch started with enable cut");
  endtask

  task automatic t_irq;
    bus(1'b0, 8'h01, 8'h01, 1'b0);
    @(posedge i_ref_clk);
    i_port_edge <= 1'b0;
    repeat (4) @(posedge i_ref_clk);
    i_port_edge <= 1'b1;
    #1;
    chk(o_irq_n === 1'b0, "irq not asserted");
    repeat (6) @(posedge i_ref_clk);
    #1;
    chk(o_irq_n === 1'b0, "flag did not stick");
    bus(1'b1, 8'h41, 8'h00, 1'b0);
    chk(o_rdata === 8'h01, "edge flag read");
    bus(1'b1, 8'h00, 8'h00, 1'b0);
    bus(1'b1, 8'h01, 8'h00, 1'b0);
    chk(o_rdata === 8'h00, "port read did not clear");
    @(posedge i_ref_clk);
    #1;
    chk(o_irq_n === 1'b1, "irq still asserted");
  endtask

  task automatic t_bank;
    bus(1'b1, 8'hfb, 8'h00, 1'b1);
    chk(o_bank === 3'h3, "bank on read");
    bus(1'b0, 8'h05, 8'h00, 1'b1);
    chk(o_bank === 3'h5, "bank on write");
  endtask

  task automatic t_fetch;
    logic [15:0] word;
    int n;
    acks = 0;
    bus(1'b0, 8'h01, 8'h06, 1'b0);
    bus(1'b0, 8'h03, 8'hff, 1'b0);
    bus(1'b0, 8'h03, 8'h12, 1'b0);
    bus(1'b0, 8'h02, 8'h00, 1'b0);
    chk(o_fetch_req === 1'b1 && o_fetch_addr === 16'h12ff, "fetch start");
    n = 0;
    while (o_pixel_valid !== 1'b1 && n < 50) begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end
    for (int k = 15; k >= 0; k--) begin
      chk(o_pixel_valid === 1'b1, "pixel valid gap");
      word[k] = o_pixel;
      @(posedge i_ref_clk);
      #1;
    end
    chk(ack_addr[0] === 16'h12ff, "first fetch address");
    chk(ack_addr[1] === 16'h1200, "no wrap in page");
    chk(word === 16'h3cc3, "word order or bit order");
    chk(o_irq_n === 1'b0, "done irq");
    bus(1'b1, 8'h07, 8'h00, 1'b0);
    @(posedge i_ref_clk);
    #1;
    chk(o_irq_n === 1'b1, "done flag not cleared");
  endtask

  initial begin
    repeat (8) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    @(posedge i_ref_clk);
    #1;
    t_reset();
    t_mirror();
    t_narrow();
    t_strobe();
    t_irq();
    t_bank();
    t_fetch();
    tally_and_finish();
  end

  // Cuts a hang short well past the hundred or so cycles the tests need
  initial begin
    #20000;
    errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    tally_and_finish();
  end
endmodule

`default_nettype wire
